// file: logic/mcr_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "mcr_defs.svh"

module mcr_top
  import mcr_pkg::*;
#(
  parameter int unsigned LED_HALF_CYC = `MCR_LED_HALF_CYC
) (
  // clock and reset
  input  wire logic       i_core_clk,
  input  wire logic       i_nrst,
  // network data words
  input  wire mcr_words_t i_out_words,
  input  wire logic       i_out_wr,
  input  wire logic       i_link_ok,
  output var  mcr_words_t o_in_words,
  // nonvolatile store
  input  wire logic       i_nv_load,
  output logic            o_nv_save_req,
  input  wire logic       i_nv_done,
  input  wire logic       i_nv_ok,
  // motion core side
  input  wire logic       i_fault,
  input  wire logic       i_gp_out_bit,
  input  wire logic       i_move_done,
  output logic            o_driver_power_on,
  output logic            o_position_report_format,
  output logic [15:0]     o_idle_pct,
  // pins
  input  wire logic [2:0] i_din_pin,
  output logic [2:0]      o_din_active,
  output logic            o_aux_out,
  output logic            o_led_green,
  output logic            o_led_red
);

  // ----------------------------------------
  // storage
  // ----------------------------------------
  mcr_words_t shadow_r;       // last captured write, host or store
  mcr_words_t active_r;       // validated working set
  logic       eval_r;         // shadow waits for evaluation
  logic       configured_r;   // active set holds a valid config
  logic       accepted_r;     // last config write was accepted
  logic       mode_prev_r;    // control mode bit, previous image
  logic       rb_hold_r;      // readback latched, writes refused
  logic       persist_prev_r; // persist bit, previous image
  logic       idle_pend_r;    // new idle value awaits move end
  logic [15:0] status9_r;     // save result for word nine
  logic       status9_vld_r;  // save result overrides word nine
  mcr_state_e state_r;        // save sequencer
  mcr_cfgw_s  cfg_act;        // active config word view
  mcr_cfgw_s  cfg_sh;         // shadow config word view
  logic       shadow_valid;   // shadow passes every check
  logic       locked;         // device stops responding

  assign cfg_act = mcr_cfgw_s'(active_r[`MCR_W_CFG]);
  assign cfg_sh  = mcr_cfgw_s'(shadow_r[`MCR_W_CFG]);
  assign locked  = (state_r == MCR_LOCKED);

  // ----------------------------------------
  // validity check
  // ----------------------------------------
  // fully combinational; one evaluation cycle after each write
  // keeps the adder-free compare chain off the write path
  function automatic logic cfg_valid(input mcr_words_t w);
    logic [2:0] f1;
    logic [2:0] f2;
    logic [2:0] f3;
    logic       enc;
    logic       ok;
    f1  = w[`MCR_W_CTL][2:0];
    f2  = w[`MCR_W_CTL][5:3];
    f3  = w[`MCR_W_CTL][8:6];
    enc = w[`MCR_W_CTL][`MCR_CTL_ENC_EN];
    ok  = 1'b1;
    // reserved bits of the config word
    ok = ok && (w[`MCR_W_CFG][`MCR_CFG_RSV_MSB:`MCR_CFG_RSV_LSB] == 6'h00);
    // split starting speed: thousands word, then remainder word
    ok = ok && (w[`MCR_W_SPD_HI] <= `MCR_SPD_HI_MAX);
    ok = ok && (w[`MCR_W_SPD_LO] <= `MCR_SPD_LO_MAX);
    ok = ok && ((w[`MCR_W_SPD_HI] != 16'h0000) || (w[`MCR_W_SPD_LO] != 16'h0000));
    // remaining parameter ranges
    ok = ok && (w[`MCR_W_STEPS] >= `MCR_STEPS_MIN);
    ok = ok && (w[`MCR_W_STEPS] <= `MCR_WORD_POS_MAX);
    ok = ok && (w[`MCR_W_HGAIN] <= `MCR_HGAIN_MAX);
    ok = ok && (w[`MCR_W_ENC_PPR] <= `MCR_WORD_POS_MAX);
    ok = ok && (w[`MCR_W_IDLE] <= `MCR_IDLE_MAX);
    ok = ok && (w[`MCR_W_RUN_CUR] >= `MCR_CUR_MIN);
    ok = ok && (w[`MCR_W_RUN_CUR] <= `MCR_CUR_MAX);
    ok = ok && (w[`MCR_W_LOOP_GAIN] >= `MCR_LGAIN_MIN);
    ok = ok && (w[`MCR_W_LOOP_GAIN] <= `MCR_LGAIN_MAX);
    // general purpose inputs may repeat, any other function may not
    ok = ok && !((f1 != `MCR_FN_GP) && ((f1 == f2) || (f1 == f3)));
    ok = ok && !((f2 != `MCR_FN_GP) && (f2 == f3));
    // encoder-dependent features
    ok = ok && (enc || !(w[`MCR_W_CTL][`MCR_CTL_HOME_Z] ||
                         w[`MCR_W_CTL][`MCR_CTL_STALL]));
    // zero pulses per turn is the one in-range value unusable with an encoder
    ok = ok && !(enc && (w[`MCR_W_ENC_PPR] == 16'h0000));
    ok = ok && (f1 != `MCR_FN_RSV) && (f2 != `MCR_FN_RSV) && (f3 != `MCR_FN_RSV);
    return ok;
  endfunction

  assign shadow_valid = cfg_valid(shadow_r);

  // ----------------------------------------
  // write capture
  // ----------------------------------------
  // once locked every write is dropped until power cycles
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      shadow_r <= '0;
      eval_r   <= 1'b0;
    end else begin
      eval_r <= 1'b0;
      if (!locked && (i_out_wr || i_nv_load)) begin
        shadow_r <= i_out_words;
        eval_r   <= 1'b1;
      end
    end
  end

  // remembers whether the pending image came from the store
  logic from_nv_r;

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      from_nv_r <= 1'b0;
    end else if (!locked && (i_out_wr || i_nv_load)) begin
      from_nv_r <= i_nv_load && !i_out_wr;
    end
  end

  // ----------------------------------------
  // evaluation and acceptance
  // ----------------------------------------
  logic cfg_mode;     // shadow asks for configuration mode
  logic entering;     // first configuration image after command mode
  logic want_rb;      // readback takes this image
  logic refuse;       // image is refused outright

  assign cfg_mode = shadow_r[`MCR_W_CTL][`MCR_CTL_MODE];
  assign entering = cfg_mode && !mode_prev_r;
  assign want_rb  = cfg_mode && cfg_sh.readback_request && (entering || rb_hold_r);
  assign refuse   = want_rb;

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      mode_prev_r <= 1'b0;
      rb_hold_r   <= 1'b0;
    end else if (eval_r && !from_nv_r) begin
      mode_prev_r <= cfg_mode;
      rb_hold_r   <= want_rb;
    end
  end

  // shadow copied into the active set only when it all checks out
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      active_r     <= '0;
      configured_r <= 1'b0;
      accepted_r   <= 1'b0;
    end else if (eval_r && !locked) begin
      if (from_nv_r) begin
        if (shadow_valid) begin
          active_r     <= shadow_r;
          configured_r <= 1'b1;
          accepted_r   <= 1'b1;
        end
      end else if (cfg_mode && !refuse) begin
        if (shadow_valid) begin
          active_r     <= shadow_r;
          configured_r <= 1'b1;
          accepted_r   <= 1'b1;
        end else begin
          accepted_r <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------
  // save sequencer
  // ----------------------------------------
  logic persist_rise; // persist bit made a zero-to-one move

  assign persist_rise = eval_r && !from_nv_r && cfg_mode && !refuse &&
                        cfg_sh.persist_request && !persist_prev_r;

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      persist_prev_r <= 1'b0;
    end else if (eval_r && !from_nv_r) begin
      persist_prev_r <= cfg_sh.persist_request;
    end
  end

  // invalid data drops the edge; the request pulse lasts one cycle
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_r       <= MCR_IDLE;
      o_nv_save_req <= 1'b0;
      status9_r     <= 16'h0000;
      status9_vld_r <= 1'b0;
    end else begin
      o_nv_save_req <= 1'b0;
      case (state_r)
        MCR_IDLE: begin
          if (persist_rise && shadow_valid) begin
            state_r       <= MCR_SAVING;
            o_nv_save_req <= 1'b1;
          end
        end
        MCR_SAVING: begin
          if (i_nv_done) begin
            state_r       <= MCR_LOCKED;
            status9_vld_r <= 1'b1;
            status9_r     <= i_nv_ok ? `MCR_SAVE_OK : `MCR_SAVE_FAIL;
          end
        end
        MCR_LOCKED: begin
          state_r <= MCR_LOCKED;
        end
        default: begin
          state_r <= MCR_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // input word image
  // ----------------------------------------
  // word zero echoes control only while the last write was taken
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_in_words    <= '0;
      o_in_words[0] <= `MCR_CTL_RESET;
    end else begin
      o_in_words[0] <= accepted_r ? active_r[`MCR_W_CTL] : `MCR_CTL_RESET;
      for (int i = 1; i < `MCR_NUM_WORDS - 1; i++) begin
        o_in_words[i] <= active_r[i];
      end
      o_in_words[`MCR_W_LOOP_GAIN] <= status9_vld_r ? status9_r
                                      : active_r[`MCR_W_LOOP_GAIN];
    end
  end

  // ----------------------------------------
  // driver and format outputs
  // ----------------------------------------
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_driver_power_on        <= 1'b0;
      o_position_report_format <= 1'b0;
    end else begin
      o_driver_power_on        <= configured_r && cfg_act.driver_power_on;
      o_position_report_format <= cfg_act.position_report_format;
    end
  end

  // ----------------------------------------
  // idle current hand-off
  // ----------------------------------------
  // a new acceptance in the same cycle as a move end keeps pending set
  logic accept_pulse;

  assign accept_pulse = eval_r && !locked && shadow_valid &&
                        (from_nv_r || (cfg_mode && !refuse));

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      idle_pend_r <= 1'b0;
      o_idle_pct  <= 16'h0000;
    end else begin
      if (accept_pulse) begin
        idle_pend_r <= 1'b1;
      end else if (i_move_done && idle_pend_r) begin
        idle_pend_r <= 1'b0;
        o_idle_pct  <= active_r[`MCR_W_IDLE];
      end
    end
  end

  // ----------------------------------------
  // discrete inputs
  // ----------------------------------------
  logic [2:0] din_meta_r; // first stage, read only by second
  logic [2:0] din_sync_r; // settled level, one means current flows
  logic [2:0] pol;        // polarity bits, input one at bit 0

  assign pol = {cfg_act.input_three_polarity, cfg_act.input_two_polarity,
                cfg_act.input_one_polarity};

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      din_meta_r <= 3'h0;
      din_sync_r <= 3'h0;
    end else begin
      din_meta_r <= i_din_pin;
      din_sync_r <= din_meta_r;
    end
  end

  // zero polarity: active with no current; one: active with current
  generate
    for (genvar g = 0; g < 3; g++) begin : g_din
      always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
          o_din_active[g] <= 1'b0;
        end else begin
          o_din_active[g] <= pol[g] ? din_sync_r[g] : !din_sync_r[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // output one
  // ----------------------------------------
  // link-ok comes from same-clock network logic, no synchroniser
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_aux_out <= 1'b1;
    end else if (!configured_r) begin
      o_aux_out <= 1'b1;
    end else if (!i_link_ok) begin
      if (cfg_act.aux_output_loss_override) begin
        o_aux_out <= cfg_act.aux_output_loss_value;
      end else begin
        o_aux_out <= o_aux_out;
      end
    end else if (cfg_act.aux_output_role) begin
      o_aux_out <= i_gp_out_bit;
    end else begin
      o_aux_out <= !i_fault;
    end
  end

  // ----------------------------------------
  // status indicator
  // ----------------------------------------
  // one divider shared by both colours; only one lights after a save
  logic [31:0] led_cnt_r;
  logic        led_phase_r;

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      led_cnt_r   <= 32'h0000_0000;
      led_phase_r <= 1'b0;
    end else if (led_cnt_r >= 32'(LED_HALF_CYC - 1)) begin
      led_cnt_r   <= 32'h0000_0000;
      led_phase_r <= !led_phase_r;
    end else begin
      led_cnt_r <= led_cnt_r + 32'h0000_0001;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_led_green <= 1'b0;
      o_led_red   <= 1'b0;
    end else begin
      o_led_green <= status9_vld_r && (status9_r == `MCR_SAVE_OK) && led_phase_r;
      o_led_red   <= status9_vld_r && (status9_r == `MCR_SAVE_FAIL) && led_phase_r;
    end
  end

endmodule

`default_nettype wire

// file: logic/mcr_defs.svh
`ifndef MCR_DEFS_SVH
`define MCR_DEFS_SVH

// ----------------------------------------
// data word indices
// ----------------------------------------
`define MCR_W_CTL        4'h0
`define MCR_W_CFG        4'h1
`define MCR_W_SPD_HI     4'h2
`define MCR_W_SPD_LO     4'h3
`define MCR_W_STEPS      4'h4
`define MCR_W_HGAIN      4'h5
`define MCR_W_ENC_PPR    4'h6
`define MCR_W_IDLE       4'h7
`define MCR_W_RUN_CUR    4'h8
`define MCR_W_LOOP_GAIN  4'h9
`define MCR_NUM_WORDS    10

// ----------------------------------------
// control word bit positions
// ----------------------------------------
`define MCR_CTL_MODE     15
`define MCR_CTL_STALL    13
`define MCR_CTL_ENC_EN   10
`define MCR_CTL_HOME_Z   9

// ----------------------------------------
// config word reserved field
// ----------------------------------------
`define MCR_CFG_RSV_MSB  8
`define MCR_CFG_RSV_LSB  3

// ----------------------------------------
// reset and status values
// ----------------------------------------
`define MCR_CTL_RESET    16'h6408
`define MCR_SAVE_OK      16'haaaa
`define MCR_SAVE_FAIL    16'heeee

// ----------------------------------------
// parameter ranges
// ----------------------------------------
`define MCR_SPD_HI_MAX   16'h07cf
`define MCR_SPD_LO_MAX   16'h03e7
`define MCR_STEPS_MIN    16'h00c8
`define MCR_WORD_POS_MAX 16'h7fff
`define MCR_HGAIN_MAX    16'h0003
`define MCR_IDLE_MAX     16'h0064
`define MCR_CUR_MIN      16'h000a
`define MCR_CUR_MAX      16'h0028
`define MCR_LGAIN_MIN    16'h0001
`define MCR_LGAIN_MAX    16'h0028
`define MCR_FN_GP        3'h0
`define MCR_FN_RSV       3'h7

// ----------------------------------------
// timing
// ----------------------------------------
`define MCR_CLK_HZ       25000000
`define MCR_LED_HALF_MS  250
`define MCR_LED_HALF_CYC ((`MCR_CLK_HZ / 1000) * `MCR_LED_HALF_MS)

`endif

// file: logic/mcr_pkg.sv
`default_nettype none

package mcr_pkg;

  // save sequencer states
  typedef enum logic [1:0] {
    MCR_IDLE   = 2'b00,
    MCR_SAVING = 2'b01,
    MCR_LOCKED = 2'b10
  } mcr_state_e;

  // configuration word fields, msb first
  typedef struct packed {
    logic       driver_power_on;
    logic       aux_output_role;
    logic       aux_output_loss_override;
    logic       aux_output_loss_value;
    logic       readback_request;
    logic       persist_request;
    logic       position_report_format;
    logic [5:0] reserved;
    logic       input_three_polarity;
    logic       input_two_polarity;
    logic       input_one_polarity;
  } mcr_cfgw_s;

  // ten-word network data image
  typedef logic [9:0][15:0] mcr_words_t;

endpackage

`default_nettype wire

// file: verification/mcr_top_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module mcr_top_monitor
  import mcr_pkg::*;
(
  // clock and reset
  input wire logic        i_core_clk,
  input wire logic        i_nrst,
  // inputs watched
  input wire logic        i_out_wr,
  input wire logic        i_nv_load,
  input wire logic        i_nv_done,
  input wire logic        i_nv_ok,
  input wire logic        i_link_ok,
  input wire logic        i_fault,
  input wire logic        i_gp_out_bit,
  input wire logic        i_move_done,
  // outputs watched
  input wire mcr_words_t  o_in_words,
  input wire logic        o_nv_save_req,
  input wire logic        o_driver_power_on,
  input wire logic [15:0] o_idle_pct,
  input wire logic        o_aux_out
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  logic cfgd;  // word 0 echoes a config-mode control word
  assign cfgd = o_in_words[0][15];
  // condition, then word 1 unmoved, so the active set is settled
  sequence s_steady(c);
    c ##1 $stable(o_in_words[1]);
  endsequence

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_reset_values: assert property (
    $rose(i_nrst) |-> o_in_words[0] == 16'h6408 && o_aux_out)
    else $error("reset values wrong");
  a_save_pulse: assert property (o_nv_save_req |=> !o_nv_save_req)
    else $error("save request longer than one cycle");
  a_save_cause: assert property (
    $rose(o_nv_save_req) |-> $past(i_out_wr, 2) || $past(i_nv_load, 2))
    else $error("save request without write");
  a_save_good: assert property (i_nv_done && i_nv_ok |-> ##2 o_in_words[9] == 16'haaaa)
    else $error("success code missing");
  a_save_bad: assert property (i_nv_done && !i_nv_ok |-> ##2 o_in_words[9] == 16'heeee)
    else $error("failure code missing");
  a_lock_freeze: assert property (
    o_in_words[9] inside {16'haaaa, 16'heeee} |=> $stable(o_in_words) && !o_nv_save_req)
    else $error("activity after save report");
  a_drv_follow: assert property (
    $changed(o_driver_power_on) |-> o_driver_power_on == o_in_words[1][15] &&
    ($past(i_out_wr, 3) || $past(i_nv_load, 3)))
    else $error("driver enable moved without accepted write");
  a_aux_fault: assert property (
    s_steady(cfgd && i_link_ok && !o_in_words[1][14]) |-> o_aux_out == !$past(i_fault))
    else $error("output one not following fault");
  a_aux_gp: assert property (
    s_steady(cfgd && i_link_ok && o_in_words[1][14]) |-> o_aux_out == $past(i_gp_out_bit))
    else $error("output one not following general bit");
  a_link_value: assert property (
    s_steady(cfgd && !i_link_ok && o_in_words[1][13]) |-> o_aux_out == o_in_words[1][12])
    else $error("output one not at loss value");
  a_link_hold: assert property (
    s_steady(cfgd && !i_link_ok && !o_in_words[1][13]) |-> $stable(o_aux_out))
    else $error("output one not held on loss");
  a_idle_move: assert property ($changed(o_idle_pct) |-> $past(i_move_done))
    else $error("idle current applied without move end");
endmodule

`default_nettype wire

// file: verification/mcr_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module mcr_host_model
  import mcr_pkg::*;
(
  // clock
  input  wire logic i_core_clk,
  // host image
  output var mcr_words_t o_words,
  output logic           o_wr,
  output logic           o_nv_load,
  // flash side
  input  wire logic i_save_req,
  input  wire logic i_fail_next,
  output logic      o_nv_done,
  output logic      o_nv_ok
);
  int unsigned busy_cnt = 0;  // flash write time left

  initial begin
    o_words = '0;
    o_wr = 1'b0;
    o_nv_load = 1'b0;
    o_nv_done = 1'b0;
    o_nv_ok = 1'b0;
  end

  // ----------------------------------------
  // image write, one strobe cycle
  // ----------------------------------------
  // reserved field comes from the caller; only invalid-image cases set it
  task automatic put(input logic [15:0] ctl, cfg, lo, enc);
    o_words = {16'h0005, 16'h0014, 16'h0032, enc, 16'h0000, 16'h00c8, lo, 16'h0000,
               cfg, ctl};
    o_wr = 1'b1;
    @(posedge i_core_clk);
    #1;
    o_wr = 1'b0;
  endtask

  // stored image handed over at power-up, one strobe cycle
  task automatic load(input logic [15:0] ctl, cfg);
    o_words = {16'h0005, 16'h0014, 16'h0032, 16'h0000, 16'h0000, 16'h00c8, 16'h0064,
               16'h0000, cfg, ctl};
    o_nv_load = 1'b1;
    @(posedge i_core_clk);
    #1;
    o_nv_load = 1'b0;
  endtask

  // ----------------------------------------
  // flash: slow answer, ok line toggles when idle
  // ----------------------------------------
  always @(posedge i_core_clk) begin
    o_nv_done <= (busy_cnt == 1);
    o_nv_ok <= (busy_cnt == 1) ? !i_fail_next : !o_nv_ok;
    if (busy_cnt != 0) begin
      busy_cnt <= busy_cnt - 1;
    end else if (i_save_req === 1'b1) begin
      busy_cnt <= 6;
    end
  end
endmodule

`default_nettype wire

// file: verification/mcr_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module mcr_top_tb_top;
  import mcr_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  typedef struct packed {
    logic [15:0] ctl;
    logic [15:0] cfg;
    logic [15:0] lo;
    logic [15:0] enc;
    logic        ok;
  } mcr_row_s;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        link = 1'b1;
  logic        fault = 1'b0;
  logic        gp = 1'b0;
  logic        move = 1'b0;
  logic        fail_next = 1'b0;
  logic [2:0]  pins = 3'h0;
  mcr_words_t  words, in_words;
  logic        wr, nv_load, nv_done, nv_ok, save_req, drv, fmt, aux, grn, red;
  logic [15:0] idle, exp_w0;
  logic [2:0]  din_act;
  logic        exp_drv = 1'b0;
  int          mismatches = 0;
  int          total_checks = 0;
  int          saves = 0;
  int          base;
  mcr_row_s    rows [11];

  always #20 clk = ~clk;
  always @(posedge clk) if (save_req === 1'b1) saves <= saves + 1;

  mcr_host_model u_host (.i_core_clk(clk), .o_words(words), .o_wr(wr), .i_save_req(save_req),
    .i_fail_next(fail_next), .o_nv_done(nv_done), .o_nv_ok(nv_ok), .o_nv_load(nv_load));

  mcr_top #(.LED_HALF_CYC(4)) dut (.i_core_clk(clk), .i_nrst(nrst), .i_out_words(words),
    .i_out_wr(wr), .i_link_ok(link), .o_in_words(in_words), .i_nv_load(nv_load),
    .o_nv_save_req(save_req), .i_nv_done(nv_done), .i_nv_ok(nv_ok), .i_fault(fault),
    .i_gp_out_bit(gp), .i_move_done(move), .o_driver_power_on(drv),
    .o_position_report_format(fmt), .o_idle_pct(idle), .i_din_pin(pins),
    .o_din_active(din_act), .o_aux_out(aux), .o_led_green(grn), .o_led_red(red));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // bounded waits; running out ends the run
  task automatic wait_save(input logic [15:0] exp, input logic want_red);
    int n;
    n = 0;
    while (({red, grn} !== {want_red, !want_red} || in_words[9] !== exp) && n < 80) begin
      tick(1);
      n++;
    end
    check("save status", in_words[9], exp);
    check("led", {14'h0, red, grn}, {14'h0, want_red, !want_red});
    check("save count", 16'(saves - base), 16'h0001);
    if (n >= 80) begin
      mismatches++;
      tally_and_finish();
    end
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rows = '{'{16'h8000, 16'h8207, 16'h0064, 16'h0000, 1'b1},
             '{16'h8000, 16'h0000, 16'h03e7, 16'h0000, 1'b1},
             '{16'h8000, 16'h8008, 16'h0064, 16'h0000, 1'b0},
             '{16'h8000, 16'h8000, 16'h03e8, 16'h0000, 1'b0},
             '{16'h8048, 16'h8000, 16'h0064, 16'h0000, 1'b0},
             '{16'h8200, 16'h8000, 16'h0064, 16'h0000, 1'b0},
             '{16'ha000, 16'h8000, 16'h0064, 16'h0000, 1'b0},
             '{16'h8400, 16'h8000, 16'h0064, 16'h0000, 1'b0},
             '{16'h8007, 16'h8000, 16'h0064, 16'h0000, 1'b0},
             '{16'h8400, 16'h8000, 16'h0064, 16'h0fa0, 1'b1},
             '{16'h8000, 16'h8000, 16'h0000, 16'h0000, 1'b0}};
    tick(20);
    nrst = 1'b1;
    tick(2);
    check("word0", in_words[0], 16'h6408);
    check("aux", {15'h0, aux}, 16'h0001);
    foreach (rows[i]) begin
      u_host.put(rows[i].ctl, rows[i].cfg, rows[i].lo, rows[i].enc);
      tick(5);
      if (rows[i].ok) begin
        exp_drv = rows[i].cfg[15];
        check("word1", in_words[1], rows[i].cfg);
        check("word9", in_words[9], 16'h0005);
        check("word3", in_words[3], rows[i].lo);
        check("word6", in_words[6], rows[i].enc);
        check("format", {15'h0, fmt}, {15'h0, rows[i].cfg[9]});
      end
      exp_w0 = rows[i].ok ? rows[i].ctl : 16'h6408;
      check("word0", in_words[0], exp_w0);
      check("driver", {15'h0, drv}, {15'h0, exp_drv});
      $display("row %0d done", i);
    end
    // idle current waits for the end of a move
    check("idle", idle, 16'h0000);
    move = 1'b1;
    tick(1);
    move = 1'b0;
    tick(2);
    check("idle", idle, 16'h0032);
    // input levels, both polarities
    pins = 3'b101;
    tick(5);
    check("din", {13'h0, din_act}, 16'h0002);
    u_host.put(16'h8000, 16'h8005, 16'h0064, 16'h0000);
    tick(5);
    check("din", {13'h0, din_act}, 16'h0007);
    // output one: fault role, general role, network loss
    fault = 1'b1;
    tick(2);
    check("aux", {15'h0, aux}, 16'h0000);
    u_host.put(16'h8000, 16'hf005, 16'h0064, 16'h0000);
    tick(5);
    check("aux", {15'h0, aux}, 16'h0000);
    link = 1'b0;
    tick(2);
    check("aux", {15'h0, aux}, 16'h0001);
    link = 1'b1;
    u_host.put(16'h8000, 16'hc005, 16'h0064, 16'h0000);
    gp = 1'b1;
    tick(5);
    link = 1'b0;
    gp = 1'b0;
    tick(2);
    check("aux", {15'h0, aux}, 16'h0001);
    link = 1'b1;
    tick(2);
    check("aux", {15'h0, aux}, 16'h0000);
    $display("output one done");
    // readback on entry refuses new data
    u_host.put(16'h0000, 16'h0000, 16'h0064, 16'h0000);
    tick(3);
    u_host.put(16'h8000, 16'h0800, 16'h0064, 16'h0000);
    tick(5);
    check("word1", in_words[1], 16'hc005);
    check("driver", {15'h0, drv}, 16'h0001);
    u_host.put(16'h8000, 16'h8800, 16'h0064, 16'h0000);
    tick(5);
    check("word1", in_words[1], 16'hc005);
    u_host.put(16'h8000, 16'h8000, 16'h0064, 16'h0000);
    tick(5);
    check("word1", in_words[1], 16'h8000);
    $display("readback done");
    // save: invalid edge ignored, then a good save locks the block
    base = saves;
    u_host.put(16'h8000, 16'h8408, 16'h0064, 16'h0000);
    tick(8);
    check("save count", 16'(saves - base), 16'h0000);
    u_host.put(16'h8000, 16'h8000, 16'h0064, 16'h0000);
    tick(3);
    u_host.put(16'h8000, 16'h8400, 16'h0064, 16'h0000);
    wait_save(16'haaaa, 1'b0);
    u_host.put(16'h8000, 16'h0000, 16'h0064, 16'h0000);
    tick(5);
    check("driver", {15'h0, drv}, 16'h0001);
    check("word1", in_words[1], 16'h8400);
    $display("save done");
    // power cycle, then a failing save
    nrst = 1'b0;
    tick(3);
    nrst = 1'b1;
    tick(2);
    check("word0", in_words[0], 16'h6408);
    u_host.load(16'h0000, 16'h8000);
    tick(5);
    check("word0", in_words[0], 16'h0000);
    check("driver", {15'h0, drv}, 16'h0001);
    fail_next = 1'b1;
    base = saves;
    u_host.put(16'h8000, 16'h8000, 16'h0064, 16'h0000);
    tick(3);
    u_host.put(16'h8000, 16'h8400, 16'h0064, 16'h0000);
    wait_save(16'heeee, 1'b1);
    $display("failed save done");
    tally_and_finish();
  end
endmodule

bind mcr_top mcr_top_monitor u_mon (.i_core_clk, .i_nrst, .i_out_wr, .i_nv_load, .i_nv_done,
  .i_nv_ok, .i_link_ok, .i_fault, .i_gp_out_bit, .i_move_done, .o_in_words, .o_nv_save_req,
  .o_driver_power_on, .o_idle_pct, .o_aux_out);

`default_nettype wire
